// File: design/dxt_pkg.sv
// Constants and types shared by the divide, extract and trap slice
package dxt_pkg;
	// Opcodes handled by the slice
	localparam logic [7:0] OPC_SIGNED_WIDE_DIV = 8'he1;
	localparam logic [7:0] OPC_DIV_LAST_R = 8'h6c;
	localparam logic [7:0] OPC_DIV_LAST_I = 8'h6d;
	localparam logic [7:0] OPC_DIV_REM_R = 8'h6e;
	localparam logic [7:0] OPC_DIV_REM_I = 8'h6f;
	localparam logic [7:0] OPC_DOUBLE_MUL = 8'hf5;
	localparam logic [7:0] OPC_DOUBLE_SUB = 8'hf3;
	localparam logic [7:0] OPC_SW_TRAP = 8'hd7;
	localparam logic [7:0] OPC_BYTE_MERGE_R = 8'h0a;
	localparam logic [7:0] OPC_BYTE_MERGE_I = 8'h0b;
	localparam logic [7:0] OPC_HW_MERGE_R = 8'h7c;
	localparam logic [7:0] OPC_HW_MERGE_I = 8'h7d;
	localparam logic [7:0] OPC_HW_SIGNEXT = 8'h7e;
	localparam logic [7:0] OPC_FUNNEL_R = 8'h7a;
	localparam logic [7:0] OPC_FUNNEL_I = 8'h7b;

	// Highest vector number that user mode may not request
	localparam logic [7:0] SW_TRAP_PROT_LIMIT = 8'h3f;

	// Register byte addresses on the Avalon-MM slave
	localparam logic [4:0] ADDR_ALU_STATUS = 5'h00;
	localparam logic [4:0] ADDR_EXT_REG = 5'h04;
	localparam logic [4:0] ADDR_IND_A = 5'h08;
	localparam logic [4:0] ADDR_IND_B = 5'h0c;
	localparam logic [4:0] ADDR_IND_C = 5'h10;
	localparam logic [4:0] ADDR_CONFIG = 5'h14;
	localparam logic [4:0] ADDR_TRAP_INFO = 5'h18;

	// ALU status field positions, and the byte-order bit of the config register
	localparam int FC_LSB = 0;
	localparam int BP_LSB = 5;
	localparam int DF_BIT = 8;
	localparam int V_BIT = 9;
	localparam int N_BIT = 10;
	localparam int Z_BIT = 11;
	localparam int C_BIT = 12;
	localparam int BO_BIT = 0;

	// Values after reset
	localparam logic [4:0] FC_RST = 5'h00;
	localparam logic [1:0] BP_RST = 2'h0;
	localparam logic [31:0] EXT_RST = 32'h0000_0000;
	localparam logic [7:0] IND_RST = 8'h00;
	localparam logic BO_RST = 1'b1;

	// Bus answer latency in cycles after the request is seen
	localparam int BUS_ACK_CYCLES = 1;

	typedef enum logic [2:0] {
		DXT_IDLE = 3'b001,
		DXT_ACK = 3'b010,
		DXT_DONE = 3'b100
	} dxt_bus_st_t;
endpackage

// File: design/dxt_unit.sv
// Divide final steps, byte and half-word extraction, funnel extract and trap raising
// Behaviour
// - signed wide divide opcode is not computed; it raises its own trap.
// - unsigned wide divide is not computed; it raises its own trap.
// - double multiply opcode raises its own trap, no product.
// - double subtract opcode raises its own trap, no difference.
// - these traps load the three pointers with first, second and target registers.
// - divide last step subtracts when divide flag set, else adds; writes target.
// - new divide flag is not(carry xor flag xor negative); negative takes sign.
// - divide last step shifts extension left, filling with new divide flag.
// - remainder step copies first source if flag set, else writes the sum.
// - immediate bit selects zero-extended 8-bit field as second source.
// - software trap loads pointers a, b with register numbers, traps to vector.
// - software trap may also change pointer c; its value has no meaning.
// - user-mode software trap with vector 0 to 63 gives protection violation.
// - byte merge puts selected first-source byte into second source low byte.
// - half-word merge puts selected half-word into second source low half.
// - half-word sign-extend writes selected half-word sign-extended to 32 bits.
// - funnel extract shifts first over second left by count, returns upper word.
// - funnel count comes from status register; equal sources give rotate.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module dxt_unit #(
	parameter logic [7:0] OPC_UNSIGNED_WIDE_DIV = 8'he0,
	parameter logic [7:0] VEC_SIGNED_WIDE_DIV = 8'h18,
	parameter logic [7:0] VEC_UNSIGNED_WIDE_DIV = 8'h19,
	parameter logic [7:0] VEC_DOUBLE_MUL = 8'h1a,
	parameter logic [7:0] VEC_DOUBLE_SUB = 8'h1b,
	parameter logic [7:0] VEC_PROT_VIOLATION = 8'h05
) (
	input wire logic clk_sys,
	input wire logic rstn,
	// Issue port from the pipeline
	input wire logic issue_valid,
	input wire logic [7:0] issue_opcode,
	input wire logic [7:0] issue_field_c,
	input wire logic [7:0] issue_field_a,
	input wire logic [7:0] issue_field_b,
	input wire logic [31:0] issue_src_a,
	input wire logic [31:0] issue_src_b,
	input wire logic issue_user_mode,
	// Result and trap answers
	output logic result_valid,
	output logic [31:0] result_data,
	output logic [7:0] result_target,
	output logic trap_valid,
	output logic [7:0] trap_vector_number,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import dxt_pkg::*;

	// Byte chosen by pointer; with big-endian order pointer zero is the top byte
	function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] bp,
		input logic big);
		logic [1:0] idx;
		idx = big ? 2'(2'd3 - bp) : bp;
		pick_byte = w[idx*8 +: 8];
	endfunction

	// Half-word chosen by the upper pointer bit and the byte order
	function automatic logic [15:0] pick_half(input logic [31:0] w, input logic [1:0] bp,
		input logic big);
		logic upper;
		upper = big ? ~bp[1] : bp[1];
		pick_half = upper ? w[31:16] : w[15:0];
	endfunction

	// Byte-enable merge for partial bus writes
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge_be = r;
	endfunction

	// Architectural state
	logic [4:0] fc_ff;
	logic [1:0] bp_ff;
	logic df_ff;
	logic v_ff;
	logic n_ff;
	logic z_ff;
	logic c_ff;
	logic [31:0] ext_ff;
	logic [7:0] ind_a_ff;
	logic [7:0] ind_b_ff;
	logic [7:0] ind_c_ff;
	logic bo_ff;
	logic [7:0] last_trap_ff;
	logic [15:0] trap_count_ff;
	logic res_valid_ff;
	logic [31:0] res_data_ff;
	logic [7:0] res_target_ff;
	logic trap_valid_ff;
	logic [7:0] trap_vec_ff;
	dxt_bus_st_t bus_st_ff;
	logic [31:0] rdata_ff;
	logic wait_ff;

	// Opcode decode
	wire is_sdiv = issue_valid && issue_opcode == OPC_SIGNED_WIDE_DIV;
	wire is_udiv = issue_valid && issue_opcode == OPC_UNSIGNED_WIDE_DIV;
	wire is_double_float_multiply = issue_valid && issue_opcode == OPC_DOUBLE_MUL;
	wire is_double_float_subtract = issue_valid && issue_opcode == OPC_DOUBLE_SUB;
	wire is_divide_last_step = issue_valid && (issue_opcode == OPC_DIV_LAST_R ||
		issue_opcode == OPC_DIV_LAST_I);
	wire is_drem = issue_valid && (issue_opcode == OPC_DIV_REM_R ||
		issue_opcode == OPC_DIV_REM_I);
	wire is_swtrap = issue_valid && issue_opcode == OPC_SW_TRAP;
	wire is_bmerge = issue_valid && (issue_opcode == OPC_BYTE_MERGE_R ||
		issue_opcode == OPC_BYTE_MERGE_I);
	wire is_hmerge = issue_valid && (issue_opcode == OPC_HW_MERGE_R ||
		issue_opcode == OPC_HW_MERGE_I);
	wire is_hsext = issue_valid && issue_opcode == OPC_HW_SIGNEXT;
	wire is_funnel = issue_valid && (issue_opcode == OPC_FUNNEL_R ||
		issue_opcode == OPC_FUNNEL_I);
	wire unimpl_trap = is_sdiv || is_udiv || is_double_float_multiply || is_double_float_subtract;

	// Second source selection
	wire imm_sel = issue_opcode[0];
	wire [31:0] src_b_eff = imm_sel ? {24'h000000, issue_field_b} : issue_src_b;

	// Divide arithmetic
	// Subtraction as addition of the complement, so carry-out comes from one adder
	wire [32:0] add_sum = {1'b0, issue_src_a} + {1'b0, src_b_eff};
	wire [32:0] sub_sum = {1'b0, issue_src_a} + {1'b0, ~src_b_eff} + 33'h000000001;
	wire [32:0] divide_last_step_sum = df_ff ? sub_sum : add_sum;
	wire divide_last_step_df = ~(divide_last_step_sum[32] ^ df_ff ^ n_ff);
	wire divide_last_step_v_add = (issue_src_a[31] == src_b_eff[31]) && (add_sum[31] != issue_src_a[31]);
	wire divide_last_step_v_sub = (issue_src_a[31] != src_b_eff[31]) && (sub_sum[31] != issue_src_a[31]);
	wire divide_last_step_v = df_ff ? divide_last_step_v_sub : divide_last_step_v_add;
	wire [31:0] drem_res = df_ff ? issue_src_a : add_sum[31:0];

	// Extraction
	wire [7:0] sel_byte = pick_byte(issue_src_a, bp_ff, bo_ff);
	wire [15:0] sel_half = pick_half(issue_src_a, bp_ff, bo_ff);
	wire [31:0] bmerge_res = {src_b_eff[31:8], sel_byte};
	wire [31:0] hmerge_res = {src_b_eff[31:16], sel_half};
	wire [31:0] hsext_res = {{16{sel_half[15]}}, sel_half};
	wire [63:0] funnel_wide = {issue_src_a, src_b_eff} << fc_ff;
	wire [31:0] funnel_res = funnel_wide[63:32];

	// Trap vector choice
	// Only the software trap is subject to the user-mode protection check
	wire sw_prot = issue_user_mode && issue_field_c <= SW_TRAP_PROT_LIMIT;
	wire [7:0] sw_vec = sw_prot ? VEC_PROT_VIOLATION : issue_field_c;
	wire [7:0] unimpl_vec = is_sdiv ? VEC_SIGNED_WIDE_DIV :
		is_udiv ? VEC_UNSIGNED_WIDE_DIV :
		is_double_float_multiply ? VEC_DOUBLE_MUL :
		VEC_DOUBLE_SUB;
	wire take_trap = unimpl_trap || is_swtrap;
	wire [7:0] nxt_trap_vec = is_swtrap ? sw_vec : unimpl_vec;

	// Result choice
	wire produce = is_divide_last_step || is_drem || is_bmerge || is_hmerge || is_hsext || is_funnel;
	wire [31:0] nxt_res_data = is_divide_last_step ? divide_last_step_sum[31:0] :
		is_drem ? drem_res :
		is_bmerge ? bmerge_res :
		is_hmerge ? hmerge_res :
		is_hsext ? hsext_res :
		funnel_res;

	// Bus decode
	wire bus_req = avs_read || avs_write;
	wire bus_fire = bus_st_ff == DXT_ACK;
	wire wr_fire = bus_fire && avs_write;
	wire wr_status = wr_fire && avs_address == ADDR_ALU_STATUS;
	wire wr_ext = wr_fire && avs_address == ADDR_EXT_REG;
	wire wr_ind_a = wr_fire && avs_address == ADDR_IND_A && avs_byteenable[0];
	wire wr_ind_b = wr_fire && avs_address == ADDR_IND_B && avs_byteenable[0];
	wire wr_ind_c = wr_fire && avs_address == ADDR_IND_C && avs_byteenable[0];
	wire wr_config = wr_fire && avs_address == ADDR_CONFIG && avs_byteenable[0];
	wire [31:0] status_word = {19'h00000, c_ff, z_ff, n_ff, v_ff, df_ff, 1'b0, bp_ff, fc_ff};
	wire [31:0] status_new = merge_be(status_word, avs_writedata, avs_byteenable);
	wire [31:0] rd_mux = avs_address == ADDR_ALU_STATUS ? status_word :
		avs_address == ADDR_EXT_REG ? ext_ff :
		avs_address == ADDR_IND_A ? {24'h000000, ind_a_ff} :
		avs_address == ADDR_IND_B ? {24'h000000, ind_b_ff} :
		avs_address == ADDR_IND_C ? {24'h000000, ind_c_ff} :
		avs_address == ADDR_CONFIG ? {31'h00000000, bo_ff} :
		avs_address == ADDR_TRAP_INFO ? {8'h00, trap_count_ff, last_trap_ff} :
		32'h0000_0000;

	// Bus handshake: one wait cycle, then waitrequest low for one cycle
	dxt_bus_st_t nxt_bus_st;
	always_comb begin
		case (bus_st_ff)
			DXT_IDLE: nxt_bus_st = bus_req ? DXT_ACK : DXT_IDLE;
			DXT_ACK: nxt_bus_st = DXT_DONE;
			DXT_DONE: nxt_bus_st = DXT_IDLE;
			default: nxt_bus_st = DXT_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bus_st_ff <= DXT_IDLE;
			rdata_ff <= 32'h0000_0000;
			wait_ff <= 1'b1;
		end else begin
			bus_st_ff <= nxt_bus_st;
			wait_ff <= nxt_bus_st != DXT_ACK;
			if (bus_st_ff == DXT_IDLE && bus_req) begin
				rdata_ff <= avs_read ? rd_mux : 32'h0000_0000;
			end
		end
	end

	// Status fields; a divide last step or remainder step in the same cycle overrides a bus write
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			fc_ff <= FC_RST;
			bp_ff <= BP_RST;
			df_ff <= 1'b0;
			v_ff <= 1'b0;
			n_ff <= 1'b0;
			z_ff <= 1'b0;
			c_ff <= 1'b0;
		end else if (is_divide_last_step) begin
			df_ff <= divide_last_step_df;
			n_ff <= divide_last_step_sum[31];
			z_ff <= divide_last_step_sum[31:0] == 32'h0000_0000;
			c_ff <= divide_last_step_sum[32];
			v_ff <= divide_last_step_v;
		end else if (is_drem) begin
			n_ff <= drem_res[31];
			z_ff <= drem_res == 32'h0000_0000;
			c_ff <= df_ff ? c_ff : add_sum[32];
			v_ff <= df_ff ? v_ff : divide_last_step_v_add;
		end else if (wr_status) begin
			fc_ff <= status_new[FC_LSB +: 5];
			bp_ff <= status_new[BP_LSB +: 2];
			df_ff <= status_new[DF_BIT];
			v_ff <= status_new[V_BIT];
			n_ff <= status_new[N_BIT];
			z_ff <= status_new[Z_BIT];
			c_ff <= status_new[C_BIT];
		end
	end

	// Extension register
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ext_ff <= EXT_RST;
		end else if (is_divide_last_step) begin
			ext_ff <= {ext_ff[30:0], divide_last_step_df};
		end else if (wr_ext) begin
			ext_ff <= merge_be(ext_ff, avs_writedata, avs_byteenable);
		end
	end

	// Indirect pointers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ind_a_ff <= IND_RST;
			ind_b_ff <= IND_RST;
			ind_c_ff <= IND_RST;
		end else if (unimpl_trap || is_swtrap) begin
			ind_a_ff <= issue_field_a;
			ind_b_ff <= issue_field_b;
			ind_c_ff <= issue_field_c;
		end else begin
			// Bus writes land only when no trap loads the pointers
			if (wr_ind_a) begin
				ind_a_ff <= avs_writedata[7:0];
			end
			if (wr_ind_b) begin
				ind_b_ff <= avs_writedata[7:0];
			end
			if (wr_ind_c) begin
				ind_c_ff <= avs_writedata[7:0];
			end
		end
	end

	// Configuration and trap bookkeeping
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			bo_ff <= BO_RST;
			last_trap_ff <= 8'h00;
			trap_count_ff <= 16'h0000;
		end else begin
			if (wr_config) begin
				bo_ff <= avs_writedata[BO_BIT];
			end
			// Count wraps; it only tells software how many traps were taken
			if (take_trap) begin
				last_trap_ff <= nxt_trap_vec;
				trap_count_ff <= 16'(trap_count_ff + 16'h0001);
			end
		end
	end

	// Answers to the pipeline
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			res_valid_ff <= 1'b0;
			res_data_ff <= 32'h0000_0000;
			res_target_ff <= 8'h00;
			trap_valid_ff <= 1'b0;
			trap_vec_ff <= 8'h00;
		end else begin
			res_valid_ff <= produce;
			if (produce) begin
				res_data_ff <= nxt_res_data;
				res_target_ff <= issue_field_c;
			end
			// Opcode sets are disjoint, so result and trap never pulse together
			trap_valid_ff <= take_trap;
			if (take_trap) begin
				trap_vec_ff <= nxt_trap_vec;
			end
		end
	end

	// Every output comes straight from its flip-flop
	assign result_valid = res_valid_ff;
	assign result_data = res_data_ff;
	assign result_target = res_target_ff;
	assign trap_valid = trap_valid_ff;
	assign trap_vector_number = trap_vec_ff;
	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
endmodule
`default_nettype wire

// File: sim/dxt_unit_props.sv
// Port checker of the divide, extract and trap slice
`timescale 1ns/1ps
`default_nettype none
module dxt_unit_props import dxt_pkg::*; #(
	parameter logic [7:0] OPC_UNSIGNED_WIDE_DIV = 8'he0,
	parameter logic [7:0] VEC_SIGNED_WIDE_DIV = 8'h18,
	parameter logic [7:0] VEC_UNSIGNED_WIDE_DIV = 8'h19,
	parameter logic [7:0] VEC_DOUBLE_MUL = 8'h1a,
	parameter logic [7:0] VEC_DOUBLE_SUB = 8'h1b,
	parameter logic [7:0] VEC_PROT_VIOLATION = 8'h05
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic issue_valid,
	input wire logic [7:0] issue_opcode,
	input wire logic [7:0] issue_field_c,
	input wire logic [31:0] issue_src_a,
	input wire logic [31:0] issue_src_b,
	input wire logic issue_user_mode,
	input wire logic result_valid,
	input wire logic [31:0] result_data,
	input wire logic trap_valid,
	input wire logic [7:0] trap_vector_number
);
	wire logic prot_hit = issue_user_mode && issue_field_c <= SW_TRAP_PROT_LIMIT;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_op(logic [7:0] op);
		issue_valid && issue_opcode == op;
	endsequence
	property p_trap(logic [7:0] op, logic [7:0] vec);
		s_op(op) |=> trap_valid && trap_vector_number == vec;
	endproperty
	a_sdiv_trap: assert property (p_trap(OPC_SIGNED_WIDE_DIV, VEC_SIGNED_WIDE_DIV))
		else $error("signed divide trap wrong");
	a_udiv_trap: assert property (p_trap(OPC_UNSIGNED_WIDE_DIV, VEC_UNSIGNED_WIDE_DIV))
		else $error("unsigned divide trap wrong");
	a_double_float_multiply_trap: assert property (p_trap(OPC_DOUBLE_MUL, VEC_DOUBLE_MUL))
		else $error("double multiply trap wrong");
	a_double_float_subtract_trap: assert property (p_trap(OPC_DOUBLE_SUB, VEC_DOUBLE_SUB))
		else $error("double subtract trap wrong");
	a_user_prot: assert property (s_op(OPC_SW_TRAP) ##0 prot_hit |=> trap_valid && trap_vector_number == VEC_PROT_VIOLATION)
		else $error("protection trap wrong");
	a_sw_vector: assert property (s_op(OPC_SW_TRAP) ##0 !prot_hit |=> trap_valid && trap_vector_number == $past(issue_field_c))
		else $error("software trap vector wrong");
	a_last_sum: assert property (s_op(OPC_DIV_LAST_R) |=> result_valid && (result_data == $past(issue_src_a) + $past(issue_src_b) || result_data == $past(issue_src_a) - $past(issue_src_b)))
		else $error("last step result wrong");
	a_rem_pick: assert property (s_op(OPC_DIV_REM_R) |=> result_valid && (result_data == $past(issue_src_a) || result_data == $past(issue_src_a) + $past(issue_src_b)))
		else $error("remainder result wrong");
	a_byte_keep: assert property (s_op(OPC_BYTE_MERGE_R) |=> result_valid && ((result_data ^ $past(issue_src_b)) >> 8) == 32'h0)
		else $error("byte merge upper bytes wrong");
	a_imm_zero: assert property (s_op(OPC_BYTE_MERGE_I) |=> result_valid && result_data[31:8] == 24'h0)
		else $error("immediate not zero extended");
	a_sext_fill: assert property (s_op(OPC_HW_SIGNEXT) |=> result_valid && result_data[31:16] == {16{result_data[15]}})
		else $error("sign extension wrong");
endmodule
bind dxt_unit dxt_unit_props #(.OPC_UNSIGNED_WIDE_DIV(OPC_UNSIGNED_WIDE_DIV),
	.VEC_SIGNED_WIDE_DIV(VEC_SIGNED_WIDE_DIV), .VEC_UNSIGNED_WIDE_DIV(VEC_UNSIGNED_WIDE_DIV),
	.VEC_DOUBLE_MUL(VEC_DOUBLE_MUL), .VEC_DOUBLE_SUB(VEC_DOUBLE_SUB),
	.VEC_PROT_VIOLATION(VEC_PROT_VIOLATION)) dxt_unit_props_i (.clk_sys, .rstn, .issue_valid,
	.issue_opcode, .issue_field_c, .issue_src_a, .issue_src_b, .issue_user_mode, .result_valid,
	.result_data, .trap_valid, .trap_vector_number);
`default_nettype wire

// File: sim/dxt_pipe_model.sv
// Pipeline model issuing one instruction per request
`timescale 1ns/1ps
`default_nettype none
module dxt_pipe_model (
	input wire logic clk_sys,
	input wire logic req,
	input wire logic [96:0] word,
	output logic issue_valid,
	output logic [96:0] issue_word
);
	initial issue_word = '0;
	// Idle issue fields invert every cycle, starting from the last word
	always @(posedge clk_sys) begin
		issue_valid <= req;
		issue_word <= req ? word : ~issue_word;
	end
endmodule
`default_nettype wire

// File: sim/test_divide_extract_trap_unit.sv
// Self-checking bench of the divide, extract and trap slice
`timescale 1ns/1ps
`default_nettype none
module test_divide_extract_trap_unit;
	import dxt_pkg::*;
	localparam logic [7:0] VEC[5] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h05};
	localparam logic [7:0] TOPS[4] = '{OPC_SIGNED_WIDE_DIV, 8'he0, OPC_DOUBLE_MUL, OPC_DOUBLE_SUB};
	logic clk_sys = 0, rstn = 0, req = 0, avs_read = 0, avs_write = 0, ord, u;
	logic [4:0] avs_address = 0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 0, rd, x, a, b, st, ex;
	logic [96:0] word = 0;
	logic [63:0] w64;
	logic [32:0] dv;
	logic [7:0] v;
	logic [1:0] ptr;
	int fails = 0, n_checks = 0;
	wire logic issue_valid, issue_user_mode;
	wire logic [7:0] issue_opcode, issue_field_c, issue_field_a, issue_field_b;
	wire logic [31:0] issue_src_a, issue_src_b;
	wire logic [96:0] issue_word;
	logic result_valid, trap_valid, avs_waitrequest;
	logic [31:0] result_data, avs_readdata;
	logic [7:0] result_target, trap_vector_number;
	assign {issue_opcode, issue_field_c, issue_field_a, issue_field_b, issue_src_a, issue_src_b,
		issue_user_mode} = issue_word;
	dxt_pipe_model dxt_pipe_model_i (.clk_sys, .req, .word, .issue_valid, .issue_word);
	dxt_unit #(.OPC_UNSIGNED_WIDE_DIV(8'he0), .VEC_SIGNED_WIDE_DIV(VEC[0]),
		.VEC_UNSIGNED_WIDE_DIV(VEC[1]), .VEC_DOUBLE_MUL(VEC[2]), .VEC_DOUBLE_SUB(VEC[3]),
		.VEC_PROT_VIOLATION(VEC[4])) dxt_unit_i (.clk_sys(clk_sys), .rstn(rstn),
		.issue_valid(issue_valid), .issue_opcode(issue_opcode), .issue_field_c(issue_field_c),
		.issue_field_a(issue_field_a), .issue_field_b(issue_field_b), .issue_src_a(issue_src_a),
		.issue_src_b(issue_src_b), .issue_user_mode(issue_user_mode),
		.result_valid(result_valid), .result_data(result_data), .result_target(result_target),
		.trap_valid(trap_valid), .trap_vector_number(trap_vector_number),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	initial forever #20 clk_sys = ~clk_sys;
	function automatic logic [32:0] f_divide_last_step(input logic [31:0] p, q, input logic f, n);
		logic [32:0] s;
		s = f ? {1'b0, p} + {1'b0, ~q} + 33'h1 : {1'b0, p} + {1'b0, q};
		return {~(s[32] ^ f ^ n), s[31:0]};
	endfunction
	// Byte or half-word picked by pointer and order, zero-extended
	function automatic logic [31:0] f_pick(input logic [31:0] p, input logic [1:0] pt, input logic o, hw);
		logic [1:0] i;
		i = o ? ~pt : pt;
		if (hw)
			return i[1] ? p[31:16] : p[15:0];
		return p[8*i +: 8];
	endfunction
	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
		@(posedge clk_sys);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= ad;
		avs_writedata <= d;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic issue(input logic [7:0] o, c, ra, rb, input logic [31:0] p, q, input logic um);
		@(posedge clk_sys);
		req <= 1'b1;
		word <= {o, c, ra, rb, p, q, um};
		@(posedge clk_sys);
		req <= 1'b0;
		for (int i = 0; i < 4 && result_valid !== 1'b1 && trap_valid !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(89));
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		bus(0, ADDR_ALU_STATUS, 0);
		chk(rd, 0);
		bus(0, ADDR_CONFIG, 0);
		chk(rd, 1);
		bus(1, 5'h1c, '1);
		bus(0, 5'h1c, 0);
		chk(rd, 0);
		avs_byteenable <= 4'h1;
		bus(1, ADDR_EXT_REG, '1);
		avs_byteenable <= 4'hf;
		bus(0, ADDR_EXT_REG, 0);
		chk(rd, 32'h0000_00ff);
		$display("reset test done");
		for (int k = 0; k < 4; k++) begin
			x = $urandom;
			issue(TOPS[k], x[7:0], x[15:8], x[23:16], $urandom, $urandom, x[24]);
			chk({trap_valid, trap_vector_number}, {1'b1, VEC[k]});
			bus(0, ADDR_IND_A, 0);
			chk(rd, x[15:8]);
			bus(0, ADDR_IND_B, 0);
			chk(rd, x[23:16]);
			bus(0, ADDR_IND_C, 0);
			chk(rd, x[7:0]);
		end
		$display("trap test done");
		st = $urandom & 32'h1f7f;
		bus(1, ADDR_ALU_STATUS, st);
		for (int k = 0; k < 8; k++) begin
			x = $urandom;
			v = k == 0 ? 8'h3f : k == 1 ? 8'h40 : x[7:0];
			u = k < 2 || x[24];
			issue(OPC_SW_TRAP, v, x[15:8], x[23:16], $urandom, $urandom, u);
			chk({trap_valid, trap_vector_number}, {1'b1, (u && v <= 8'h3f) ? VEC[4] : v});
			bus(0, ADDR_IND_A, 0);
			chk(rd, x[15:8]);
			bus(0, ADDR_IND_B, 0);
			chk(rd, x[23:16]);
		end
		bus(0, ADDR_ALU_STATUS, 0);
		chk(rd, st);
		$display("software trap test done");
		for (int k = 0; k < 8; k++) begin
			{ord, ptr} = k[2:0];
			x = $urandom;
			a = $urandom;
			b = $urandom;
			st = x & 32'h1f1f | ptr << 5;
			bus(1, ADDR_CONFIG, ord);
			bus(1, ADDR_ALU_STATUS, st);
			issue(OPC_BYTE_MERGE_R, x[7:0], 8'h1, 8'h2, a, b, 0);
			chk(result_data, b & 32'hffffff00 | f_pick(a, ptr, ord, 0));
			chk(result_target, x[7:0]);
			issue(OPC_BYTE_MERGE_I, 0, 0, x[15:8], a, b, 0);
			chk(result_data, f_pick(a, ptr, ord, 0));
			if (!ptr[0]) begin
				ex = f_pick(a, ptr, ord, 1);
				issue(OPC_HW_MERGE_R, 0, 0, 0, a, b, 0);
				chk(result_data, b & 32'hffff0000 | ex);
				issue(OPC_HW_MERGE_I, 0, 0, x[15:8], a, b, 0);
				chk(result_data, ex);
				issue(OPC_HW_SIGNEXT, 0, 0, 0, a, b, 0);
				chk(result_data, {{16{ex[15]}}, ex[15:0]});
			end
			bus(0, ADDR_ALU_STATUS, 0);
			chk(rd, st);
		end
		$display("extract test done");
		for (int k = 0; k < 6; k++) begin
			x = $urandom;
			a = $urandom;
			b = k == 2 ? a : $urandom;
			st = k == 0 ? 0 : k == 1 ? 31 : x & 32'h1f;
			bus(1, ADDR_ALU_STATUS, st);
			issue(k[0] ? OPC_FUNNEL_I : OPC_FUNNEL_R, 0, 0, x[15:8], a, b, 0);
			if (k[0])
				b = x[15:8];
			w64 = {a, b} << st[4:0];
			chk(result_data, w64[63:32]);
		end
		$display("funnel test done");
		for (int k = 0; k < 12; k++) begin
			x = $urandom;
			a = $urandom;
			b = $urandom;
			ex = $urandom;
			v = {6'h1b, k[1:0]};
			st = x & 32'h1fff;
			bus(1, ADDR_ALU_STATUS, st);
			bus(1, ADDR_EXT_REG, ex);
			issue(v, 0, 0, x[23:16], a, b, 0);
			if (v[0])
				b = x[23:16];
			dv = f_divide_last_step(a, b, st[8], st[10]);
			if (v[1])
				chk(result_data, st[8] ? a : a + b);
			else begin
				chk(result_data, dv[31:0]);
				bus(0, ADDR_ALU_STATUS, 0);
				chk(rd & 32'h500, {dv[31], 1'b0, dv[32], 8'h0});
				bus(0, ADDR_EXT_REG, 0);
				chk(rd, {ex[30:0], dv[32]});
			end
		end
		$display("divide test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
